// file: src/acr_config_bank.sv
// Purpose: Configuration register bank of a dual-channel converter behind a three-wire serial port
// Assumes: Serial pins asynchronous to ref_clk; SCLK much slower than ref_clk
// Notes: Program registers are double-buffered; the transfer bit commits them together
`timescale 1ns/10ps
`default_nettype none
module acr_config_bank #(
	parameter logic [acr_pkg::BYTE_W-1:0] DEVICE_IDENTIFIER = 8'hA5,
	parameter logic [2:0] SPEED_GRADE = 3'h0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Serial port pins
	input wire logic sclk,
	input wire logic csb,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	// External power-down pin
	input wire logic power_down_pin,
	// Active per-channel operating state
	output logic [acr_pkg::NUM_CH-1:0][1:0] chan_op_mode,
	output logic [acr_pkg::NUM_CH-1:0] chan_power_down,
	output logic [acr_pkg::NUM_CH-1:0] chan_standby,
	output logic digital_reset,
	// Active clock settings
	output logic duty_cycle_stabilizer,
	output logic [acr_pkg::DIV_W-1:0] clk_div_ratio,
	output logic conv_clk_en
);
	import acr_pkg::*;

	typedef struct packed {
		logic lsb_first;
		logic soft_rst;
		logic [NUM_CH-1:0] chan_sel;
		logic [NUM_CH-1:0][BYTE_W-1:0] mst_modes;
		logic mst_dcs;
		logic [DIV_W-1:0] mst_div;
		logic xfer;
		logic [NUM_CH-1:0][BYTE_W-1:0] act_modes;
		logic act_dcs;
		logic [DIV_W-1:0] act_div;
		logic [1:0] pin_s;
		logic [DIV_W-1:0] div_cnt;
		logic conv_en;
		logic [NUM_CH-1:0] pd;
		logic [NUM_CH-1:0] sb;
		logic drst;
	} acr_bank_state_t;

	acr_bank_state_t q;
	acr_bank_state_t d;
	acr_reg_if rif ();
	logic pin_req;
	acr_op_t op;

	acr_spi_slave u_spi (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.sclk(sclk),
		.csb(csb),
		.sdio_in(sdio_in),
		.sdio_out(sdio_out),
		.sdio_oe_n(sdio_oe_n),
		.rif(rif.spi_side)
	);

	// Channel whose local copy a read returns
	function automatic int read_chan(input logic [NUM_CH-1:0] sel);
		begin
			read_chan = (sel[CHAN_A] || !sel[CHAN_B]) ? CHAN_A : CHAN_B;
		end
	endfunction

	// Mirrored port configuration value
	function automatic logic [BYTE_W-1:0] port_cfg_value(input logic lsb, input logic srst);
		logic [BYTE_W-1:0] v;
		begin
			v = RST_PORT_CFG;
			v[PCFG_LSB_HI] = lsb;
			v[PCFG_LSB_LO] = lsb;
			v[PCFG_SRST_HI] = srst;
			v[PCFG_SRST_LO] = srst;
			port_cfg_value = v;
		end
	endfunction

	// Register readback; master copies are what the host wrote
	function automatic logic [BYTE_W-1:0] read_value(input acr_bank_state_t s,
		input logic [ADDR_W-1:0] a);
		logic [BYTE_W-1:0] v;
		begin
			v = RD_UNMAPPED;
			case (a)
				ADDR_PORT_CFG:
					v = port_cfg_value(s.lsb_first, s.soft_rst);
				ADDR_DEV_ID:
					v = DEVICE_IDENTIFIER;
				ADDR_GRADE:
					v[GRADE_LO+2:GRADE_LO] = SPEED_GRADE;
				ADDR_CHAN_SEL:
					v[NUM_CH-1:0] = s.chan_sel;
				ADDR_MODES:
					v = s.mst_modes[read_chan(s.chan_sel)];
				ADDR_CLOCK:
					v[DCS_BIT] = s.mst_dcs;
				ADDR_CLK_DIV:
					v[DIV_W-1:0] = s.mst_div;
				ADDR_XFER:
					v[XFER_BIT] = s.xfer;
				default:
					v = RD_UNMAPPED;
			endcase
			read_value = v;
		end
	endfunction

	assign rif.rdata = read_value(q, rif.rd_addr);
	assign rif.lsb_first = q.lsb_first;

	always_comb
	begin
		d = q;
		pin_req = 1'b0;
		op = OP_RUN;
		d.pin_s = {q.pin_s[0], power_down_pin};
		d.conv_en = 1'b0;

		// Converter clock enable every ratio plus one cycles
		if (q.div_cnt >= q.act_div)
		begin
			d.div_cnt = 3'h0;
			d.conv_en = 1'b1;
		end
		else
			d.div_cnt = q.div_cnt + 3'h1;

		// Commit pending settings in one cycle, then the bit drops
		if (q.xfer)
		begin
			d.act_modes = q.mst_modes;
			d.act_dcs = q.mst_dcs;
			d.act_div = q.mst_div;
			d.xfer = 1'b0;
		end

		// Soft reset also restores the active copies so operation matches readback
		if (q.soft_rst)
		begin
			d.lsb_first = 1'b0;
			d.soft_rst = 1'b0;
			d.chan_sel = RST_CHAN_SEL;
			d.mst_modes = {NUM_CH{RST_MODES}};
			d.act_modes = {NUM_CH{RST_MODES}};
			d.mst_dcs = RST_DCS;
			d.act_dcs = RST_DCS;
			d.mst_div = RST_CLK_DIV;
			d.act_div = RST_CLK_DIV;
			d.xfer = 1'b0;
		end

		if (rif.wr_stb)
		begin
			case (rif.wr_addr)
				ADDR_PORT_CFG:
				begin
					// Either mirrored copy counts, whatever the shift order was
					d.lsb_first = rif.wdata[PCFG_LSB_HI] | rif.wdata[PCFG_LSB_LO];
					d.soft_rst = rif.wdata[PCFG_SRST_HI] | rif.wdata[PCFG_SRST_LO];
				end
				ADDR_CHAN_SEL:
					d.chan_sel = rif.wdata[NUM_CH-1:0];
				ADDR_MODES:
					for (int c = 0; c < NUM_CH; c++)
					begin
						if (q.chan_sel[c])
							d.mst_modes[c] = rif.wdata & MODES_MASK;
					end
				ADDR_CLOCK:
					d.mst_dcs = rif.wdata[DCS_BIT];
				ADDR_CLK_DIV:
					d.mst_div = rif.wdata[DIV_W-1:0];
				ADDR_XFER:
					d.xfer = rif.wdata[XFER_BIT];
				default:
					d.xfer = d.xfer;
			endcase
		end

		// Decoded from the next active copy so power flags move in the same cycle as the mode outputs
		d.drst = 1'b0;
		for (int c = 0; c < NUM_CH; c++)
		begin
			op = acr_op_t'(d.act_modes[c][MODES_OP_HI:MODES_OP_LO]);
			pin_req = q.pin_s[1] & d.act_modes[c][MODES_PIN_EN];
			d.pd[c] = (op == OP_POWER_DOWN_PIN) ||
				(pin_req && d.act_modes[c][MODES_PINFN_HI:MODES_PINFN_LO] != PINFN_STBY);
			d.sb[c] = (op == OP_STBY) ||
				(pin_req && d.act_modes[c][MODES_PINFN_HI:MODES_PINFN_LO] == PINFN_STBY);
			if (op == OP_DRST)
				d.drst = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			q <= '0;
			q.chan_sel <= RST_CHAN_SEL;
			q.mst_modes <= {NUM_CH{RST_MODES}};
			q.act_modes <= {NUM_CH{RST_MODES}};
			q.mst_dcs <= RST_DCS;
			q.act_dcs <= RST_DCS;
			q.mst_div <= RST_CLK_DIV;
			q.act_div <= RST_CLK_DIV;
		end
		else
			q <= d;
	end

	// Outputs straight from state flops
	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
			chan_op_mode[c] = q.act_modes[c][MODES_OP_HI:MODES_OP_LO];
	end
	assign chan_power_down = q.pd;
	assign chan_standby = q.sb;
	assign digital_reset = q.drst;
	assign duty_cycle_stabilizer = q.act_dcs;
	assign clk_div_ratio = q.act_div;
	assign conv_clk_en = q.conv_en;
endmodule
`default_nettype wire

// file: src/acr_pkg.sv
// Purpose: Shared constants and types for the ADC serial configuration register bank
// Assumes: 13-bit register address, 8-bit registers, two converter channels
// Notes: Offsets, field positions and reset values live here only
package acr_pkg;

	localparam int ADDR_W = 13;
	localparam int BYTE_W = 8;
	localparam int INSTR_W = 16;
	localparam int INSTR_RW_BIT = 15;
	localparam int NUM_CH = 2;
	localparam int DIV_W = 3;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 13'h0000;
	localparam logic [ADDR_W-1:0] ADDR_DEV_ID = 13'h0001;
	localparam logic [ADDR_W-1:0] ADDR_GRADE = 13'h0002;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_SEL = 13'h0005;
	localparam logic [ADDR_W-1:0] ADDR_MODES = 13'h0008;
	localparam logic [ADDR_W-1:0] ADDR_CLOCK = 13'h0009;
	localparam logic [ADDR_W-1:0] ADDR_CLK_DIV = 13'h000B;
	localparam logic [ADDR_W-1:0] ADDR_XFER = 13'h00FF;

	// Reset values
	localparam logic [BYTE_W-1:0] RST_PORT_CFG = 8'h18;
	localparam logic [NUM_CH-1:0] RST_CHAN_SEL = 2'h3;
	localparam logic [BYTE_W-1:0] RST_MODES = 8'h80;
	localparam logic RST_DCS = 1'h0;
	localparam logic [DIV_W-1:0] RST_CLK_DIV = 3'h0;
	localparam logic [BYTE_W-1:0] RD_UNMAPPED = 8'h00;

	// Port configuration fields, mirrored across nibbles
	localparam int PCFG_LSB_HI = 6;
	localparam int PCFG_LSB_LO = 1;
	localparam int PCFG_SRST_HI = 5;
	localparam int PCFG_SRST_LO = 2;

	// Channel select, transfer, clock fields
	localparam int CHAN_A = 0;
	localparam int CHAN_B = 1;
	localparam int XFER_BIT = 0;
	localparam int DCS_BIT = 0;
	localparam int GRADE_LO = 4;

	// Operating mode register fields
	localparam int MODES_PIN_EN = 7;
	localparam int MODES_PINFN_HI = 6;
	localparam int MODES_PINFN_LO = 5;
	localparam int MODES_OP_HI = 1;
	localparam int MODES_OP_LO = 0;
	localparam logic [BYTE_W-1:0] MODES_MASK = 8'hE3;
	localparam logic [1:0] PINFN_STBY = 2'h1;

	typedef enum logic [1:0] {
		OP_RUN = 2'h0,
		OP_POWER_DOWN_PIN = 2'h1,
		OP_STBY = 2'h2,
		OP_DRST = 2'h3
	} acr_op_t;

	typedef enum logic [1:0] {
		SPI_INSTR = 2'h1,
		SPI_DATA = 2'h2
	} acr_spi_st_t;

endpackage

// file: src/acr_reg_if.sv
// Purpose: Register access carrier between serial front end and register bank
// Assumes: Single ref_clk domain on both sides
// Notes: Write strobe is a one-cycle pulse; read data is combinational from the bank
`timescale 1ns/10ps
`default_nettype none
interface acr_reg_if;
	import acr_pkg::*;
	logic wr_stb;
	logic [ADDR_W-1:0] wr_addr;
	logic [BYTE_W-1:0] wdata;
	logic [ADDR_W-1:0] rd_addr;
	logic [BYTE_W-1:0] rdata;
	logic lsb_first;

	modport spi_side (
		output wr_stb,
		output wr_addr,
		output wdata,
		output rd_addr,
		input rdata,
		input lsb_first
	);

	modport bank_side (
		input wr_stb,
		input wr_addr,
		input wdata,
		input rd_addr,
		output rdata,
		output lsb_first
	);
endinterface
`default_nettype wire

// file: src/acr_spi_slave.sv
// Purpose: Oversampled three-wire serial slave; 16-bit instruction then data bytes
// Assumes: SCLK well below a quarter of ref_clk; pins asynchronous to ref_clk
// Notes: Address steps down in MSB-first mode, up in LSB-first mode
`timescale 1ns/10ps
`default_nettype none
module acr_spi_slave (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Serial pins
	input wire logic sclk,
	input wire logic csb,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	// Register access
	acr_reg_if.spi_side rif
);
	import acr_pkg::*;

	typedef struct packed {
		logic [1:0] sclk_s;
		logic [1:0] csb_s;
		logic [1:0] sdi_s;
		logic sclk_prev;
		acr_spi_st_t st;
		logic [4:0] cnt;
		logic [INSTR_W-1:0] sh;
		logic is_read;
		logic [ADDR_W-1:0] addr;
		logic load;
		logic [BYTE_W-1:0] obuf;
		logic sdo;
		logic oe_n;
		logic wr;
		logic [ADDR_W-1:0] wr_addr;
		logic [BYTE_W-1:0] wdata;
	} acr_spi_state_t;

	acr_spi_state_t q;
	acr_spi_state_t d;
	logic rise;
	logic fall;
	logic [INSTR_W-1:0] sh_n;
	logic [BYTE_W-1:0] byte_n;
	logic [ADDR_W-1:0] addr_step;

	always_comb
	begin
		d = q;
		d.sclk_s = {q.sclk_s[0], sclk};
		d.csb_s = {q.csb_s[0], csb};
		d.sdi_s = {q.sdi_s[0], sdio_in};
		d.sclk_prev = q.sclk_s[1];
		rise = q.sclk_s[1] & ~q.sclk_prev;
		fall = ~q.sclk_s[1] & q.sclk_prev;
		// LSB-first shifts in at the top so the word ends up in the same place
		sh_n = rif.lsb_first ? {q.sdi_s[1], q.sh[INSTR_W-1:1]} : {q.sh[INSTR_W-2:0], q.sdi_s[1]};
		byte_n = rif.lsb_first ? sh_n[INSTR_W-1:BYTE_W] : sh_n[BYTE_W-1:0];
		addr_step = rif.lsb_first ? q.addr + 13'h0001 : q.addr - 13'h0001;
		d.wr = 1'b0;
		d.load = 1'b0;
		if (q.csb_s[1])
		begin
			d.st = SPI_INSTR;
			d.cnt = 5'h00;
			d.oe_n = 1'b1;
		end
		else
		begin
			if (q.load)
				d.obuf = rif.rdata;
			if (rise)
			begin
				d.sh = sh_n;
				d.cnt = q.cnt + 5'h01;
				case (q.st)
					SPI_INSTR:
						if (q.cnt == 5'(INSTR_W - 1))
						begin
							d.st = SPI_DATA;
							d.cnt = 5'h00;
							d.is_read = sh_n[INSTR_RW_BIT];
							d.addr = sh_n[ADDR_W-1:0];
							d.load = sh_n[INSTR_RW_BIT];
						end
					SPI_DATA:
						if (q.cnt == 5'(BYTE_W - 1))
						begin
							d.cnt = 5'h00;
							d.addr = addr_step;
							if (q.is_read)
								d.load = 1'b1;
							else
							begin
								d.wr = 1'b1;
								d.wr_addr = q.addr;
								d.wdata = byte_n;
							end
						end
					default:
						d.st = SPI_INSTR;
				endcase
			end
			// Drive readback on the falling edge so the host samples it on the rising one
			if (fall && q.st == SPI_DATA && q.is_read)
			begin
				d.oe_n = 1'b0;
				d.sdo = rif.lsb_first ? q.obuf[q.cnt[2:0]] : q.obuf[3'h7 - q.cnt[2:0]];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			q <= '0;
			q.csb_s <= 2'h3;
			q.oe_n <= 1'b1;
			q.st <= SPI_INSTR;
		end
		else
			q <= d;
	end

	assign sdio_out = q.sdo;
	assign sdio_oe_n = q.oe_n;
	assign rif.wr_stb = q.wr;
	assign rif.wr_addr = q.wr_addr;
	assign rif.wdata = q.wdata;
	assign rif.rd_addr = q.addr;
endmodule
`default_nettype wire

// file: verif/acr_config_bank_asserts.sv
// Purpose: Port-level checks of the config bank outputs
// Assumes: Single ref_clk domain, nrst active low
// Notes: Bound to every acr_config_bank instance
`timescale 1ns/10ps
`default_nettype none
module acr_bank_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Serial and pin inputs
	input wire logic csb,
	input wire logic sdio_oe_n,
	input wire logic power_down_pin,
	// Active state
	input wire logic [acr_pkg::NUM_CH-1:0][1:0] chan_op_mode,
	input wire logic [acr_pkg::NUM_CH-1:0] chan_power_down,
	input wire logic [acr_pkg::NUM_CH-1:0] chan_standby,
	input wire logic digital_reset,
	input wire logic duty_cycle_stabilizer,
	input wire logic [acr_pkg::DIV_W-1:0] clk_div_ratio,
	input wire logic conv_clk_en
);
	import acr_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_DRST: assert property (digital_reset == (chan_op_mode[0] == OP_DRST || chan_op_mode[1] == OP_DRST))
		else $error("digital reset disagrees with modes");
	AST_POWER_DOWN_PIN: assert property (chan_op_mode[0] == OP_POWER_DOWN_PIN |-> chan_power_down[0])
		else $error("channel A mode 01 without power-down");
	AST_STBY: assert property (chan_op_mode[1] == OP_STBY |-> chan_standby[1])
		else $error("channel B mode 10 without standby");
	AST_RUN: assert property ((!power_down_pin)[*6] ##0 chan_op_mode == '0 |-> chan_power_down == '0 && chan_standby == '0)
		else $error("run mode shows low power state");
	AST_CAD: assert property (clk_div_ratio == 3'h0 [*3] |-> conv_clk_en)
		else $error("divide by one lost a pulse");
	AST_GAP: assert property (conv_clk_en && clk_div_ratio != 3'h0 |=> !conv_clk_en || $changed(clk_div_ratio))
		else $error("divided clock pulses back to back");
	AST_PER: assert property (conv_clk_en |-> ##[1:8] conv_clk_en)
		else $error("divided clock period too long");
	AST_OE: assert property (csb [*6] |-> sdio_oe_n)
		else $error("data pin driven outside a frame");
	AST_SHADOW: assert property (csb [*8] |-> $stable(chan_op_mode) && $stable(clk_div_ratio) && $stable(duty_cycle_stabilizer))
		else $error("active settings moved while idle");
	cover property (clk_div_ratio == 3'h7 && conv_clk_en);
	cover property (!sdio_oe_n);
	cover property (digital_reset);
	cover property (chan_standby == 2'h3);
endmodule
bind acr_config_bank acr_bank_asserts u_chk (.ref_clk, .nrst, .csb, .sdio_oe_n, .power_down_pin, .chan_op_mode,
	.chan_power_down, .chan_standby, .digital_reset, .duty_cycle_stabilizer, .clk_div_ratio, .conv_clk_en);
`default_nettype wire

// file: verif/acr_spi_host.sv
// Purpose: Host model driving the three-wire serial port of the config bank
// Assumes: SCLK idles low and stands still between frames; hp >= 6 cycles
// Notes: Released SDIO shows a toggling pattern, never the last value
`timescale 1ns/10ps
`default_nettype none
module acr_spi_host (
	// Clock
	input wire logic ref_clk,
	// Serial pins
	output logic sclk,
	output logic csb,
	output logic sdio_pin,
	input wire logic sdio_out,
	input wire logic sdio_oe_n
);
	logic drv_en = 1'b0;
	logic drv_d = 1'b0;
	logic last_q = 1'b0;
	int hp = 6;
	initial
	begin
		sclk = 1'b0;
		csb = 1'b1;
	end
	// Device wins the wire while it reads back
	assign sdio_pin = !sdio_oe_n ? sdio_out : (drv_en ? drv_d : ~last_q);
	always @(posedge ref_clk) last_q <= sdio_pin;
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// One-byte frame; must be entered at a clock edge
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, input logic lsb,
		output logic [7:0] q);
		logic [23:0] v;
		int k;
		v = {rd, 2'h0, a, wd};
		q = 8'h00;
		csb <= 1'b0;
		for (int i = 0; i < 24; i++)
		begin
			k = lsb ? (i < 16 ? 8 + i : i - 16) : 23 - i;
			sclk <= 1'b0;
			drv_en <= !(rd && i > 15);
			drv_d <= v[k];
			cyc(hp);
			if (rd && i > 15)
				q[lsb ? i - 16 : 23 - i] = sdio_pin;
			sclk <= 1'b1;
			cyc(hp);
		end
		sclk <= 1'b0;
		cyc(hp);
		csb <= 1'b1;
		cyc(6);
	endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the config bank through its serial port
// Assumes: Host model in u_host, xorshift stimulus from a fixed seed
// Notes: Expected values come from bench literals, package constants and the lowp function
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import acr_pkg::*;
	localparam logic [7:0] TB_ID = 8'h3C; // Arbitrary value
	localparam logic [2:0] TB_GRADE = 3'h5;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic power_down_pin = 1'b0;
	logic sclk, csb, sdio_pin, sdio_out, sdio_oe_n, digital_reset, duty_cycle_stabilizer, conv_clk_en;
	logic [NUM_CH-1:0][1:0] chan_op_mode;
	logic [NUM_CH-1:0] chan_power_down, chan_standby;
	logic [DIV_W-1:0] clk_div_ratio;
	int miscompares = 0;
	int checked = 0;
	logic [31:0] seed = 32'h159E;
	logic lsb = 1'b0;
	logic [7:0] q, t, ma, mb;
	int n;
	always #5 ref_clk = ~ref_clk;
	acr_config_bank #(.DEVICE_IDENTIFIER(TB_ID), .SPEED_GRADE(TB_GRADE)) u_dut (.ref_clk, .nrst, .sclk, .csb,
		.sdio_in(sdio_pin), .sdio_out, .sdio_oe_n, .power_down_pin, .chan_op_mode, .chan_power_down,
		.chan_standby, .digital_reset, .duty_cycle_stabilizer, .clk_div_ratio, .conv_clk_en);
	acr_spi_host u_host (.ref_clk, .sclk, .csb, .sdio_pin, .sdio_out, .sdio_oe_n);
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	// {power-down, standby} of one channel
	function automatic logic [1:0] lowp(input logic [7:0] m, input logic pin);
		logic p;
		p = m[MODES_PIN_EN] && pin;
		return {m[1:0] == OP_POWER_DOWN_PIN || (p && m[6:5] != PINFN_STBY), m[1:0] == OP_STBY || (p && m[6:5] == PINFN_STBY)};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [7:0] a, input logic [7:0] b, input logic pin);
		logic [1:0] la, lb;
		la = lowp(a, pin);
		lb = lowp(b, pin);
		chk({chan_op_mode, chan_power_down, chan_standby}, {b[1:0], a[1:0], lb[1], la[1], lb[0], la[0]});
		chk({7'h00, digital_reset}, {7'h00, a[1:0] == OP_DRST || b[1:0] == OP_DRST});
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		u_host.xfer(1'b0, a, d, lsb, q);
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		u_host.xfer(1'b1, a, 8'h00, lsb, q);
		chk(q, e);
	endtask
	task automatic finish_test();
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge ref_clk);
		miscompares++;
		finish_test();
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(ADDR_PORT_CFG, RST_PORT_CFG);
		rd(ADDR_CHAN_SEL, 8'h03);
		rd(ADDR_MODES, RST_MODES);
		rd(ADDR_CLK_DIV, 8'h00);
		wr(ADDR_DEV_ID, rnd());
		rd(ADDR_DEV_ID, TB_ID);
		wr(ADDR_GRADE, rnd());
		rd(ADDR_GRADE, {1'b0, TB_GRADE, 4'h0});
		rd(13'h0003, RD_UNMAPPED);
		power_down_pin <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk_out(RST_MODES, RST_MODES, 1'b1);
		wr(ADDR_MODES, 8'hA0);
		wr(ADDR_XFER, 8'h01);
		chk_out(8'hA0, 8'hA0, 1'b1);
		power_down_pin <= 1'b0;
		ma = 8'hA0;
		mb = 8'hA0;
		for (int i = 0; i < 4; i++)
		begin
			t = rnd();
			wr(ADDR_CHAN_SEL, 8'h01);
			wr(ADDR_MODES, {1'b0, t[6:5], 3'h0, 2'(i)});
			wr(ADDR_CHAN_SEL, 8'h02);
			wr(ADDR_MODES, {1'b0, t[2:1], 3'h0, 2'(3 - i)});
			chk_out(ma, mb, 1'b0);
			wr(ADDR_CHAN_SEL, 8'h03);
			rd(ADDR_MODES, {1'b0, t[6:5], 3'h0, 2'(i)});
			wr(ADDR_XFER, 8'h01);
			ma = {1'b0, t[6:5], 3'h0, 2'(i)};
			mb = {1'b0, t[2:1], 3'h0, 2'(3 - i)};
			chk_out(ma, mb, 1'b0);
			rd(ADDR_XFER, 8'h00);
		end
		u_host.hp = 11;
		for (int j = 0; j < 4; j++)
		begin
			t = j == 1 ? 8'h0F : (j == 2 ? 8'h00 : rnd());
			wr(ADDR_CLK_DIV, {5'h00, t[2:0]});
			wr(ADDR_CLOCK, {7'h00, t[3]});
			wr(ADDR_XFER, 8'h01);
			chk({4'h0, duty_cycle_stabilizer, clk_div_ratio}, {4'h0, t[3:0]});
			for (int k = 0; k < 20 && conv_clk_en !== 1'b1; k++)
				@(posedge ref_clk);
			@(posedge ref_clk);
			for (n = 1; n < 20 && conv_clk_en !== 1'b1; n++)
				@(posedge ref_clk);
			chk(8'(n), {5'h00, t[2:0]} + 8'h01);
		end
		wr(ADDR_PORT_CFG, 8'h42);
		lsb = 1'b1;
		rd(ADDR_PORT_CFG, 8'h5A);
		wr(ADDR_CHAN_SEL, 8'h01);
		rd(ADDR_CHAN_SEL, 8'h01);
		wr(ADDR_PORT_CFG, 8'h24);
		lsb = 1'b0;
		rd(ADDR_PORT_CFG, RST_PORT_CFG);
		rd(ADDR_CHAN_SEL, 8'h03);
		chk({5'h00, clk_div_ratio}, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
